// ### dds_profile_dither_keying_ctrl.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "dds_ctrl_map.svh"

module dds_profile_dither_keying_ctrl #(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // host pins
  input wire logic io_update,
  input wire logic [1:0] profile_pins,
  input wire logic shaped_keying_pin,
  input wire logic ram_phase_dest,
  // data path
  input wire logic [16:0] phase_acc,
  input wire logic [13:0] ram_phase,
  input wire logic [13:0] core_amp,
  // outputs
  output logic [16:0] phase_word,
  output logic [13:0] amp_word,
  output logic [13:0] scale_factor,
  output logic scale_bypass,
  output logic [1:0] active_profile,
  output logic [ADDR_W-1:0] ram_addr,
  output logic sync_clk_out
);

  dds_ctrl_pkg::state_s s_r, s_nxt;

  // ===========================================
  // decode helpers
  // ===========================================
  // last profile index of a sequencing code
  function automatic logic [1:0] last_prof(input logic [2:0] code);
    last_prof = code[1:0] == 2'h0 ? 2'h1 : (code[2] ? code[1:0] : code[1:0]);
    if (code[2])
      last_prof = code[1:0] + 2'h1;
  endfunction

  // code 111 and 000 mean inactive
  function automatic logic seq_active(input logic [2:0] code);
    seq_active = (code != 3'h0) && (code != 3'h7);
  endfunction

  function automatic logic [9:0] seg_field(input logic [39:0] v, input logic [1:0] p);
    seg_field = v[p*10 +: 10];
  endfunction

  // ===========================================
  // next state
  // ===========================================
  logic [2:0] code;
  logic upd_edge;
  logic [13:0] step;
  logic [13:0] limit;
  logic [14:0] up_sum;
  logic [3:0] pdither;
  logic [3:0] dith_sel;
  logic [3:0] dith_bits;

  // ===========================================
  // phase dither mask
  // ===========================================
  // one select and one random bit per dithered phase position
  for (genvar g = 0; g < 4; g++)
  begin : g_dith
    assign dith_sel[g] = s_r.cw1_act[`CW1_PDITHER_LO + g];
    assign dith_bits[g] = dith_sel[g] & s_r.dither_shift_register[g];
  end

  always_comb
  begin
    s_nxt = s_r;
    code = s_r.cw1_act[`CW1_PROFILE_HI:`CW1_PROFILE_LO];
    step = 14'h1 << s_r.asf_act[15:14];
    limit = s_r.asf_act[13:0];
    up_sum = {1'b0, s_r.scale} + {1'b0, step};
    upd_edge = 1'b0;
    pdither = 4'h0;

    // register writes other than the segment addresses land in the buffer set
    if (reg_wr)
    begin
      unique case (reg_addr)
        `REG_CW1: s_nxt.cw1 = reg_wdata;
        `REG_PHASE: s_nxt.phase_ofs = reg_wdata[13:0];
        `REG_ASF: s_nxt.amplitude_scale_factor = reg_wdata[15:0];
        `REG_ARR: s_nxt.amplitude_ramp_rate = reg_wdata[7:0];
        `REG_SEG_FINAL: s_nxt.seg_final = {s_nxt.seg_final[39:32], reg_wdata};
        `REG_SEG_BEGIN: s_nxt.seg_begin = {s_nxt.seg_begin[39:32], reg_wdata};
        default: s_nxt.cw1 = s_nxt.cw1;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `REG_CW1: s_nxt.rdata = s_r.cw1;
        `REG_PHASE: s_nxt.rdata = {18'h0, s_r.phase_ofs};
        `REG_ASF: s_nxt.rdata = {16'h0, s_r.amplitude_scale_factor};
        `REG_ARR: s_nxt.rdata = {24'h0, s_r.amplitude_ramp_rate};
        `REG_SEG_FINAL: s_nxt.rdata = s_r.seg_final[31:0];
        `REG_SEG_BEGIN: s_nxt.rdata = s_r.seg_begin[31:0];
        `REG_STATUS: s_nxt.rdata = {10'h0, s_r.scale, s_r.seq, s_r.prof, 4'h0};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    else
      s_nxt.rdata = 32'h0;

    // divide by four gives the sync enable
    s_nxt.div = s_r.div + 2'h1;
    s_nxt.sync_en = (s_r.div == 2'(`SYNC_DIV - 1));
    s_nxt.sync_out = s_r.div[1];

    // update sampled on sync rate only; pending bit keeps a short strobe
    if (io_update)
      s_nxt.upd_pend = 1'b1;
    if (s_r.sync_en)
    begin
      s_nxt.upd_d = s_r.upd_pend;
      s_nxt.upd_pend = io_update;
      upd_edge = s_r.upd_pend && !s_r.upd_d;
    end

    if (upd_edge)
    begin
      s_nxt.cw1_act = s_r.cw1;
      s_nxt.phase_act = s_r.phase_ofs;
      s_nxt.asf_act = s_r.amplitude_scale_factor;
      s_nxt.arr_act = s_r.amplitude_ramp_rate;
    end
    // decode the code being made active, so an update from idle starts the burst
    code = s_nxt.cw1_act[`CW1_PROFILE_HI:`CW1_PROFILE_LO];

    // ===========================================
    // profile sequencer
    // ===========================================
    if (!seq_active(code))
    begin
      s_nxt.seq = dds_ctrl_pkg::SEQ_IDLE;
      s_nxt.prof = profile_pins;
    end
    else if (upd_edge)
    begin
      // restart at profile 0 begin address
      s_nxt.seq = dds_ctrl_pkg::SEQ_RUN;
      s_nxt.prof = 2'h0;
      s_nxt.addr = seg_field(s_r.seg_begin, 2'h0);
    end
    else if (s_r.sync_en)
    begin
      unique case (s_r.seq)
        dds_ctrl_pkg::SEQ_IDLE:
        begin
          s_nxt.seq = dds_ctrl_pkg::SEQ_IDLE;
        end
        dds_ctrl_pkg::SEQ_RUN:
        begin
          // every profile is a ramp-up walk
          if (s_r.addr != seg_field(s_r.seg_final, s_r.prof))
            s_nxt.addr = s_r.addr + 10'h1;
          // advance only at final segment address
          else if (s_r.prof != last_prof(code))
          begin
            s_nxt.prof = s_r.prof + 2'h1;
            s_nxt.addr = seg_field(s_r.seg_begin, s_r.prof + 2'h1);
          end
          else if (code[2])
          begin
            s_nxt.prof = 2'h0;
            s_nxt.addr = seg_field(s_r.seg_begin, 2'h0);
          end
          else
            s_nxt.seq = dds_ctrl_pkg::SEQ_DONE;
        end
        dds_ctrl_pkg::SEQ_DONE:
        begin
          s_nxt.seq = dds_ctrl_pkg::SEQ_DONE;
        end
      endcase
    end

    // ===========================================
    // dither generator
    // ===========================================
    // steps at sync rate while any enable set
    if (s_r.sync_en && |s_r.cw1_act[`CW1_DITHER_HI:`CW1_DITHER_LO])
      s_nxt.dither_shift_register = {s_r.dither_shift_register[30:0], s_r.dither_shift_register[31] ^ s_r.dither_shift_register[21] ^ s_r.dither_shift_register[1] ^ s_r.dither_shift_register[0]};

    s_nxt.phase_out = phase_acc + {3'h0, ram_phase_dest ? ram_phase : s_r.phase_act};
    pdither = dith_sel;
    s_nxt.phase_out[`PHASE_DITHER_BASE +: 4] = (s_nxt.phase_out[`PHASE_DITHER_BASE +: 4] & ~pdither) | dith_bits;

    // amplitude dither only when bit 20 set
    s_nxt.amp_out = s_r.cw1_act[`CW1_AMP_DITHER] ? (core_amp ^ {12'h0, s_r.dither_shift_register[5:4]}) : core_amp;

    // ===========================================
    // shaped keying
    // ===========================================
    s_nxt.key_d = shaped_keying_pin;
    s_nxt.key_auto_d = s_r.cw1_act[`CW1_KEY_EN] && s_r.cw1_act[`CW1_KEY_AUTO];
    if (s_nxt.key_auto_d && (!s_r.key_auto_d || shaped_keying_pin != s_r.key_d
        || (upd_edge && s_r.cw1_act[`CW1_LOAD_TIMER])))
      s_nxt.ramp_cnt = s_r.arr_act;
    else if (s_r.key_auto_d && s_r.sync_en)
    begin
      if (s_r.ramp_cnt <= 8'h1)
      begin
        s_nxt.ramp_cnt = s_r.arr_act;
        if (shaped_keying_pin)
          s_nxt.scale = (up_sum > {1'b0, limit}) ? limit : up_sum[13:0];
        else
          s_nxt.scale = (s_r.scale < step) ? 14'h0 : s_r.scale - step;
      end
      else
        s_nxt.ramp_cnt = s_r.ramp_cnt - 8'h1;
    end

    s_nxt.scale_bypass = !s_r.cw1_act[`CW1_KEY_EN];
    s_nxt.mult_out = s_r.cw1_act[`CW1_KEY_AUTO] ? s_r.scale : s_r.asf_act[13:0];
    s_nxt.prof_out = s_r.prof;
    s_nxt.addr_out = s_r.addr;
  end

  // ===========================================
  // state register
  // ===========================================
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.cw1 <= `CW1_RESET;
      s_r.cw1_act <= `CW1_RESET;
      s_r.dither_shift_register <= `DITHER_SEED;
      s_r.scale_bypass <= 1'b1;
      s_r.seq <= dds_ctrl_pkg::SEQ_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign phase_word = s_r.phase_out;
  assign amp_word = s_r.amp_out;
  assign scale_factor = s_r.mult_out;
  assign scale_bypass = s_r.scale_bypass;
  assign active_profile = s_r.prof_out;
  assign ram_addr = ADDR_W'(s_r.addr_out);
  assign sync_clk_out = s_r.sync_out;

endmodule // dds_profile_dither_keying_ctrl

// ### dds_ctrl_map.svh
`ifndef DDS_CTRL_MAP_SVH
`define DDS_CTRL_MAP_SVH

// control word one field positions
`define CW1_PROFILE_HI 29
`define CW1_PROFILE_LO 27
`define CW1_LOAD_TIMER 26
`define CW1_KEY_EN 25
`define CW1_KEY_AUTO 24
`define CW1_AMP_DITHER 20
`define CW1_DITHER_HI 20
`define CW1_DITHER_LO 16
`define CW1_PDITHER_HI 19
`define CW1_PDITHER_LO 16
`define CW1_RESET 32'h0000_0000

// register index on the plain port
`define REG_CW1 3'h0
`define REG_PHASE 3'h1
`define REG_ASF 3'h2
`define REG_ARR 3'h3
`define REG_SEG_FINAL 3'h4
`define REG_SEG_BEGIN 3'h5
`define REG_STATUS 3'h6

// sync clock divide ratio and dither seed
`define SYNC_DIV 4
`define DITHER_SEED 32'h0000_0001
// phase word bit of lowest dithered position
`define PHASE_DITHER_BASE 13

`endif

// ### dds_ctrl_pkg.sv
package dds_ctrl_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_e;

  typedef struct packed {
    logic [31:0] cw1;
    logic [13:0] phase_ofs;
    logic [15:0] amplitude_scale_factor;
    logic [7:0] amplitude_ramp_rate;
    logic [39:0] seg_final;
    logic [39:0] seg_begin;
    logic [31:0] cw1_act;
    logic [13:0] phase_act;
    logic [15:0] asf_act;
    logic [7:0] arr_act;
    logic [1:0] div;
    logic sync_en;
    logic upd_d;
    logic upd_pend;
    seq_e seq;
    logic [1:0] prof;
    logic [9:0] addr;
    logic [31:0] dither_shift_register;
    logic [13:0] scale;
    logic [7:0] ramp_cnt;
    logic key_d;
    logic key_auto_d;
    logic [31:0] rdata;
    logic [16:0] phase_out;
    logic [13:0] amp_out;
    logic [13:0] mult_out;
    logic scale_bypass;
    logic [1:0] prof_out;
    logic [9:0] addr_out;
    logic sync_out;
  } state_s;
endpackage

// ### dds_ctrl_sva.sv
`timescale 1ns/1ps
// ==========
// port checker
module dds_ctrl_chk #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // pins and data
  input wire logic io_update,
  input wire logic ram_phase_dest,
  input wire logic [16:0] phase_acc,
  input wire logic [13:0] ram_phase,
  input wire logic [16:0] phase_word,
  input wire logic scale_bypass,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic sync_clk_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_SYNC_PERIOD: assert property ($rose(sync_clk_out) |=> !$rose(sync_clk_out) [*3] ##1 $rose(sync_clk_out))
    else $error("sync period wrong");
  AST_SYNC_DUTY: assert property ($rose(sync_clk_out) |-> sync_clk_out [*2] ##1 !sync_clk_out)
    else $error("sync duty wrong");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_BYPASS_HOLD: assert property (!io_update [*8] |=> $stable(scale_bypass))
    else $error("bypass changed without update");
  AST_ADDR_STEP: assert property ($changed(ram_addr) |=> $stable(ram_addr) [*3])
    else $error("address stepped off sync");
  AST_STATIC_OFS: assert property ((!io_update && !ram_phase_dest) [*8] |->
    13'(phase_word[12:0] - $past(phase_acc[12:0])) == 13'($past(phase_word[12:0]) - $past(phase_acc[12:0], 2)))
    else $error("static offset drifted");
  AST_RAM_OFS: assert property (ram_phase_dest |=>
    phase_word[12:0] == 13'($past(phase_acc[12:0]) + $past(ram_phase[12:0])))
    else $error("ram offset not applied");
endmodule // dds_ctrl_chk

bind dds_profile_dither_keying_ctrl dds_ctrl_chk #(.ADDR_W(ADDR_W)) chk (.clk, .rstn, .reg_addr, .reg_rd,
  .reg_rdata, .io_update, .ram_phase_dest, .phase_acc, .ram_phase, .phase_word, .scale_bypass, .ram_addr, .sync_clk_out);

// ### host_pins.sv
`timescale 1ns/1ps
// ==========
// host pin driver
module host_pins (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench requests
  input wire logic upd_req,
  input wire logic key_up,
  input wire logic [1:0] prof_req,
  // device pins
  output logic io_update,
  output logic shaped_keying_pin,
  output logic [1:0] profile_pins
);
  logic [3:0] cnt_r;
  // update pulse
  // two sync periods high then low, so exactly one edge is seen
  assign io_update = cnt_r > 4'h7;
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_r <= 4'h0;
    else if (upd_req && cnt_r == 4'h0)
      cnt_r <= 4'hF;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  always_ff @(posedge clk)
  begin
    shaped_keying_pin <= key_up;
    profile_pins <= prof_req;
  end
endmodule // host_pins

// ### testbench.sv
`timescale 1ns/1ps
`include "dds_ctrl_map.svh"
// ==========
// bench top
module testbench;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, upd_req = 1'b0, key_up = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic io_update, shaped_keying_pin, ram_phase_dest = 1'b0, scale_bypass, sync_clk_out, wrap, dif;
  logic [1:0] profile_pins, active_profile, prof_req = 2'h3, mx, prv, seen;
  logic [16:0] phase_acc = 17'h1_5555, phase_word;
  logic [13:0] ram_phase = 14'h0ABC, core_amp = 14'h1234, amp_word, scale_factor;
  logic [9:0] ram_addr;
  int n_fail = 0, cmp_count = 0;
  always #5 clk = ~clk;
  dds_profile_dither_keying_ctrl #(.ADDR_W(10)) dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .io_update, .profile_pins, .shaped_keying_pin, .ram_phase_dest, .phase_acc, .ram_phase, .core_amp,
    .phase_word, .amp_word, .scale_factor, .scale_bypass, .active_profile, .ram_addr, .sync_clk_out);
  host_pins host (.clk, .rstn, .upd_req, .key_up, .prof_req, .io_update, .shaped_keying_pin, .profile_pins);
  // ==========
  // access tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask
  // register writes other than the segment addresses stay buffered until this
  task automatic upd(input int n);
    @(posedge clk);
    upd_req <= 1'b1;
    @(posedge clk);
    upd_req <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // tests
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk("bypass", 32'h1, scale_bypass);
    wr(3'h7, 32'hFFFF_FFFF);
    rd(3'h7, 32'h0, "unmapped");
    wr(`REG_SEG_BEGIN, 32'h0100_2000);
    wr(`REG_SEG_FINAL, 32'h8120_2802);
    wr(`REG_ASF, 32'h0000_C155);
    wr(`REG_CW1, 32'h0100_0000);
    upd(24);
    chk("bypass", 32'h1, scale_bypass);
    wr(`REG_CW1, 32'h0200_0000);
    upd(24);
    chk("bypass", 32'h0, scale_bypass);
    chk("manual", 32'h0155, scale_factor);
    rd(`REG_CW1, 32'h0200_0000, "cw1");
    // auto ramp clamps at the scale register
    wr(`REG_ASF, 32'h0000_0010);
    wr(`REG_ARR, 32'h0000_0001);
    wr(`REG_CW1, 32'h0300_0000);
    key_up <= 1'b1;
    upd(300);
    chk("ramp_up", 32'h10, scale_factor);
    key_up <= 1'b0;
    upd(300);
    chk("ramp_down", 32'h0, scale_factor);
    wr(`REG_CW1, 32'h0001_0000);
    upd(24);
    seen = 2'b00;
    repeat (64)
    begin
      @(posedge clk);
      #1 seen[phase_word[13]] = 1'b1;
      chk("ph_hi", phase_acc[16:14], phase_word[16:14]);
    end
    chk("ph_rand", 32'h3, seen);
    wr(`REG_CW1, 32'h0010_0000);
    upd(24);
    dif = 1'b0;
    repeat (32)
    begin
      @(posedge clk);
      #1 dif |= amp_word !== core_amp;
      chk("amp_hi", core_amp[13:2], amp_word[13:2]);
    end
    chk("amp_rand", 32'h1, dif);
    wr(`REG_PHASE, 32'h0000_0123);
    wr(`REG_CW1, 32'h0);
    upd(24);
    chk("amp", core_amp, amp_word);
    chk("phase", phase_acc + 17'h0123, phase_word);
    ram_phase_dest <= 1'b1;
    upd(16);
    chk("ram_ph", phase_acc + 17'(ram_phase), phase_word);
    ram_phase_dest <= 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      wr(`REG_CW1, 32'(c) << 27);
      upd(12);
      if (c == 0 || c == 7)
        chk("pins", 32'h3, active_profile);
      else
        chk("start", 32'h0, active_profile);
      mx = 2'h0;
      wrap = 1'b0;
      repeat (150)
      begin
        prv = active_profile;
        @(posedge clk);
        #1;
        if (active_profile > mx)
          mx = active_profile;
        if (active_profile == 2'h0 && prv != 2'h0)
          wrap = 1'b1;
      end
      if (c > 0 && c < 7)
      begin
        chk("last", (c < 4) ? c : c - 3, mx);
        chk("loop", c > 3, wrap);
      end
      if (c > 0 && c < 4)
        chk("end_addr", (c == 1) ? 10 : (c == 2) ? 18 : 2, ram_addr);
      if (c == 3)
        rd(`REG_STATUS, 32'h0000_00B0, "status");
    end
    test_done();
  end
  initial
  begin
    #100us;
    n_fail++;
    test_done();
  end
endmodule // testbench
